// [hdl/fifo_flag_pkg.sv]
package fifo_flag_pkg;
  localparam int          DATA_W          = 18;
  localparam int          BYTE_W          = 9;
  localparam int          PTR_W           = 14;
  localparam int          OFF_W           = 13;
  localparam int          SHIFT_W         = 2 * OFF_W;
  localparam int          BUF_ENTRIES     = 2;
  localparam logic [13:0] DEPTH_WORDS     = 14'h0800;
  localparam logic [13:0] DEPTH_BYTES     = 14'h1000;
  localparam logic [12:0] FULL_OFFSET_RST = 13'h007f;
  localparam logic [12:0] EMPTY_OFFSET_RST = 13'h007f;
  localparam logic        ALMOST_FULL_RST = 1'b1;
  localparam logic        ALMOST_EMPTY_RST = 1'b0;
  localparam logic        HALF_FULL_RST   = 1'b1;
  localparam logic [1:0]  BUF_COUNT_FULL  = 2'h2;
endpackage

// [hdl/fifo_status_flags_and_echo.sv]
`timescale 1ns/100ps
// Operation
// R1: Almost-full low at full-offset threshold
// R2: Standard mode: low after depth minus offset writes
// R3: Depth counts bytes only when both ports byte-wide
// R4: Fall-through mode: one more write needed
// R5: Async almost-full: set on write, clear on read
// R6: Sync almost-full changes on write edges only
// R7: Retransmit compares write pointer to mark
// R8: Standard almost-empty low at offset or fewer
// R9: Fall-through almost-empty low at offset plus one
// R10: Async almost-empty: set on read, clear on write
// R11: Sync almost-empty changes on read edges only
// R12: Half-full low on write passing half depth
// R13: Half-full high on read reaching half depth
// R14: Standard half-full after half depth plus one
// R15: Fall-through half-full one write later
// R16: Half-full updated from both sides, asynchronous
// R17: Echo read clock follows read clock always
// R18: Echo strobe low for each real read
// R19: Serial offset bits shift while load enabled
// R20: Byte-wide output uses lower nine bits only
// R21: Timing select latched in master reset
// R22: Pointers cross sides Gray-coded, two stages
// R23: Offsets reset-loaded, used as thresholds directly
module fifo_status_flags_and_echo
  import fifo_flag_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              master_reset_n,
  input  wire logic                              partial_reset_n,
  input  wire logic                              flag_timing_select,
  input  wire logic                              first_word_fall_through,
  input  wire logic                              input_is_byte,
  input  wire logic                              output_is_byte,
  input  wire logic                              write_clock,
  input  wire logic                              write_enable,
  input  wire logic                              read_clock,
  input  wire logic                              read_enable_n,
  input  wire logic                              read_chip_select_n,
  input  wire logic                              retransmit_active,
  input  wire logic [fifo_flag_pkg::PTR_W-1:0]   mark_pointer,
  input  wire logic [fifo_flag_pkg::DATA_W-1:0]  read_word,
  input  wire logic                              serial_clock,
  input  wire logic                              serial_load_enable_n,
  input  wire logic                              serial_in,
  input  wire logic                              data_ready,
  output logic      [fifo_flag_pkg::PTR_W-1:0]   write_address,
  output logic      [fifo_flag_pkg::PTR_W-1:0]   read_address,
  output logic      [fifo_flag_pkg::DATA_W-1:0]  data_out,
  output logic                                   data_valid,
  output logic                                   almost_full_n,
  output logic                                   almost_empty_n,
  output logic                                   half_full_n,
  output logic                                   read_clock_echo,
  output logic                                   read_strobe_echo_n
);
  import fifo_flag_pkg::*;

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic              wclk_q, rclk_q, sclk_q;
  logic              timing_sync_q, first_word_fall_through_q, in_byte_q, out_byte_q;
  logic [OFF_W-1:0]  full_off_q, empty_off_q;
  logic [PTR_W-1:0]  wr_ptr_q, rd_ptr_q, wr_ptr_d, rd_ptr_d;
  logic [PTR_W-1:0]  wr_gray_q, wr_sync1_q, wr_sync2_q;
  logic [PTR_W-1:0]  rd_gray_q, rd_sync1_q, rd_sync2_q;
  logic [DATA_W-1:0] buf_q [BUF_ENTRIES];
  logic              buf_wr_idx_q, buf_rd_idx_q;
  logic [1:0]        buf_cnt_q;

  wire wr_edge     = write_clock & ~wclk_q;
  wire rd_edge     = read_clock & ~rclk_q;
  wire serial_edge = serial_clock & ~sclk_q;
  wire any_reset   = ~master_reset_n | ~partial_reset_n;

  // Byte counting only when both sides are byte-wide
  wire [PTR_W-1:0] depth_units = (in_byte_q & out_byte_q) ? DEPTH_BYTES : DEPTH_WORDS; // see R3
  wire [PTR_W-1:0] first_word_fall_through_add    = {{(PTR_W-1){1'b0}}, first_word_fall_through_q};
  wire [PTR_W-1:0] capacity    = depth_units + first_word_fall_through_add;
  wire [PTR_W-1:0] fill_now    = wr_ptr_q - rd_ptr_q;
  wire             buf_in_ready = buf_cnt_q != BUF_COUNT_FULL;
  wire             write_go = wr_edge & write_enable & (fill_now != capacity) & ~any_reset;
  // A full output buffer stalls the read rather than dropping a word
  wire             read_go  = rd_edge & ~read_enable_n & ~read_chip_select_n
                              & (fill_now != '0) & buf_in_ready & ~any_reset;
  wire             buf_pop  = data_valid & data_ready;

  assign wr_ptr_d = wr_ptr_q + {{(PTR_W-1){1'b0}}, write_go};
  assign rd_ptr_d = rd_ptr_q + {{(PTR_W-1){1'b0}}, read_go};

  // In sync mode each side sees the other's pointer two stages late
  wire [PTR_W-1:0] rd_view_w = gray2bin(rd_sync2_q); // see R22
  wire [PTR_W-1:0] wr_view_r = gray2bin(wr_sync2_q); // see R22
  wire [PTR_W-1:0] af_base_a = retransmit_active ? mark_pointer : rd_ptr_d; // see R7
  wire [PTR_W-1:0] af_base_s = retransmit_active ? mark_pointer : rd_view_w; // see R7
  wire [PTR_W-1:0] fill_d    = wr_ptr_d - rd_ptr_d;

  wire [PTR_W-1:0] af_thr = depth_units - {1'b0, full_off_q} + first_word_fall_through_add; // see R1 R2 R4 R23
  wire [PTR_W-1:0] ae_thr = {1'b0, empty_off_q} + first_word_fall_through_add; // see R8 R9 R23
  wire [PTR_W-1:0] hf_thr = (depth_units >> 1) + first_word_fall_through_add; // see R14 R15

  wire af_async_hit = (wr_ptr_d - af_base_a) >= af_thr; // see R1
  wire af_sync_hit  = (wr_ptr_d - af_base_s) >= af_thr; // see R1
  wire ae_async_hit = fill_d <= ae_thr; // see R8 R9
  wire ae_sync_hit  = (wr_view_r - rd_ptr_d) <= ae_thr; // see R8 R9
  wire hf_hit       = fill_d > hf_thr;

  wire [DATA_W-1:0] push_word = out_byte_q ? {{(DATA_W-BYTE_W){1'b0}}, read_word[BYTE_W-1:0]}
                                           : read_word; // see R20

  assign write_address = wr_ptr_q;
  assign read_address  = rd_ptr_q;
  assign data_valid    = buf_cnt_q != 2'h0;
  assign data_out      = buf_q[buf_rd_idx_q];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      wclk_q <= write_clock;
      rclk_q <= read_clock;
      sclk_q <= serial_clock;
    end
  end

  // Mode pins matter only while master reset is held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timing_sync_q <= 1'b0;
      first_word_fall_through_q        <= 1'b0;
      in_byte_q     <= 1'b0;
      out_byte_q    <= 1'b0;
    end else if (!master_reset_n) begin
      timing_sync_q <= flag_timing_select; // see R21
      first_word_fall_through_q        <= first_word_fall_through;
      in_byte_q     <= input_is_byte;
      out_byte_q    <= output_is_byte;
    end
  end

  // Serial chain: empty offset in the low half, first bit ends in its LSB
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_off_q  <= FULL_OFFSET_RST;
      empty_off_q <= EMPTY_OFFSET_RST;
    end else if (!master_reset_n) begin
      full_off_q  <= FULL_OFFSET_RST; // see R23
      empty_off_q <= EMPTY_OFFSET_RST; // see R23
    end else if (serial_edge && !serial_load_enable_n) begin
      {full_off_q, empty_off_q} <= {serial_in, full_off_q, empty_off_q[OFF_W-1:1]}; // see R19
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (any_reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {wr_gray_q, wr_sync1_q, wr_sync2_q} <= '0;
      {rd_gray_q, rd_sync1_q, rd_sync2_q} <= '0;
    end else if (any_reset) begin
      {wr_gray_q, wr_sync1_q, wr_sync2_q} <= '0;
      {rd_gray_q, rd_sync1_q, rd_sync2_q} <= '0;
    end else begin
      wr_gray_q  <= bin2gray(wr_ptr_d); // see R22
      wr_sync1_q <= wr_gray_q;
      wr_sync2_q <= wr_sync1_q;
      rd_gray_q  <= bin2gray(rd_ptr_d); // see R22
      rd_sync1_q <= rd_gray_q;
      rd_sync2_q <= rd_sync1_q;
    end
  end

  // Async mode: each flag set by one side, released by the other
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      almost_full_n  <= ALMOST_FULL_RST;
      almost_empty_n <= ALMOST_EMPTY_RST;
      half_full_n    <= HALF_FULL_RST;
    end else if (any_reset) begin
      almost_full_n  <= ALMOST_FULL_RST;
      almost_empty_n <= ALMOST_EMPTY_RST;
      half_full_n    <= HALF_FULL_RST;
    end else begin
      if (timing_sync_q) begin
        if (wr_edge) almost_full_n <= ~af_sync_hit; // see R6
        if (rd_edge) almost_empty_n <= ~ae_sync_hit; // see R11
      end else begin
        if (wr_edge && af_async_hit) almost_full_n <= 1'b0; // see R5
        else if (rd_edge && !af_async_hit) almost_full_n <= 1'b1; // see R5
        if (rd_edge && ae_async_hit) almost_empty_n <= 1'b0; // see R10
        else if (wr_edge && !ae_async_hit) almost_empty_n <= 1'b1; // see R10
      end
      if (wr_edge && hf_hit) half_full_n <= 1'b0; // see R12 R16
      else if (rd_edge && !hf_hit) half_full_n <= 1'b1; // see R13 R16
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_clock_echo    <= 1'b0;
      read_strobe_echo_n <= 1'b1;
    end else begin
      read_clock_echo <= read_clock; // see R17
      if (any_reset) read_strobe_echo_n <= 1'b1;
      else if (rd_edge) read_strobe_echo_n <= ~read_go; // see R18
    end
  end

  // Two-entry output buffer; indexes wrap naturally at one bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_wr_idx_q <= 1'b0;
      buf_rd_idx_q <= 1'b0;
      buf_cnt_q    <= 2'h0;
    end else if (any_reset) begin
      buf_wr_idx_q <= 1'b0;
      buf_rd_idx_q <= 1'b0;
      buf_cnt_q    <= 2'h0;
    end else begin
      if (read_go) buf_wr_idx_q <= ~buf_wr_idx_q;
      if (buf_pop) buf_rd_idx_q <= ~buf_rd_idx_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, read_go} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge clk) begin
    if (read_go) buf_q[buf_wr_idx_q] <= push_word;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_quiet;
    master_reset_n && partial_reset_n;
  endsequence
  sequence s_read_taken;
    rd_edge && read_go;
  endsequence
  // Refused read: empty, or buffer cannot take another word
  sequence s_read_refused;
    rd_edge && !read_go;
  endsequence

  chk_af_sync_value: assert property ((s_quiet and (timing_sync_q && wr_edge)) // see R1
    |=> almost_full_n == !$past(af_sync_hit)) else $error("almost-full wrong after write");
  chk_af_async_set: assert property ((!timing_sync_q && $fell(almost_full_n)) // see R5
    |-> $past(wr_edge)) else $error("almost-full fell without write edge");
  chk_af_sync_hold: assert property ((s_quiet and (timing_sync_q && !wr_edge)) // see R6
    |=> $stable(almost_full_n)) else $error("almost-full moved off write edge");
  chk_ae_async_clr: assert property ((!timing_sync_q && $rose(almost_empty_n)) // see R10
    |-> $past(wr_edge)) else $error("almost-empty rose without write edge");
  chk_ae_sync_hold: assert property ((s_quiet and (timing_sync_q && !rd_edge)) // see R11
    |=> $stable(almost_empty_n)) else $error("almost-empty moved off read edge");
  chk_hf_set_edge: assert property ($fell(half_full_n) |-> $past(wr_edge) && $past(hf_hit)) // see R12
    else $error("half-full fell without write");
  chk_hf_clear_edge: assert property ($rose(half_full_n) // see R13
    |-> ($past(rd_edge) && !$past(hf_hit)) || $past(any_reset)) else $error("half-full rose badly");
  chk_echo_clock: assert property (##1 read_clock_echo == $past(read_clock)) // see R17
    else $error("echo clock not a one-cycle copy");
  chk_echo_strobe_low: assert property (s_read_taken |=> !read_strobe_echo_n ##1 // see R18
    (!read_strobe_echo_n || $past(any_reset))) else $error("echo strobe missed a read");
  chk_byte_out_width: assert property ((out_byte_q && data_valid) // see R20
    |-> data_out[DATA_W-1:BYTE_W] == '0) else $error("byte output upper bits set");
  chk_serial_shift: assert property ((s_quiet and (serial_edge && !serial_load_enable_n)) // see R19
    |=> full_off_q[OFF_W-1] == $past(serial_in)) else $error("serial bit not captured");
  chk_timing_latch: assert property (!master_reset_n |=> timing_sync_q == $past(flag_timing_select)) // see R21
    else $error("timing select not latched");
  chk_af_async_clr: assert property ((!timing_sync_q && $rose(almost_full_n)) // see R5
    |-> ($past(rd_edge) && !$past(af_async_hit)) || $past(any_reset))
    else $error("almost-full rose off read edge");
  chk_ae_async_set: assert property ((!timing_sync_q && $fell(almost_empty_n)) // see R10
    |-> ($past(rd_edge) && $past(ae_async_hit)) || $past(any_reset))
    else $error("almost-empty fell off read edge");
  chk_ae_sync_value: assert property ((s_quiet and (timing_sync_q && rd_edge)) // see R11
    |=> almost_empty_n == !$past(ae_sync_hit)) else $error("almost-empty wrong after read");
  chk_echo_strobe_high: assert property ((s_quiet and s_read_refused) // see R18
    |=> read_strobe_echo_n) else $error("echo strobe low on refused read");
  chk_read_ptr_hold: assert property ((s_quiet and s_read_refused) // see R18
    |=> $stable(read_address)) else $error("read pointer moved on refused read");
  chk_write_advance: assert property ((s_quiet and (wr_edge && write_enable // see R2
    && fill_now != capacity)) |=> write_address == $past(write_address) + 14'h0001)
    else $error("write pointer did not advance");
endmodule // fifo_status_flags_and_echo

// [test/far_side_model.sv]
`timescale 1ns/100ps
module far_side_model
  import fifo_flag_pkg::*;
(
  input  wire logic [fifo_flag_pkg::PTR_W-1:0]  read_address,
  input  wire logic                             stall,
  output logic      [fifo_flag_pkg::DATA_W-1:0] read_word,
  output logic                                  data_ready
);
  import fifo_flag_pkg::*;
  // Address-derived contents, so words at any 512 consecutive addresses differ
  assign read_word = {read_address[8:0], read_address[8:0] ^ 9'h1a5};
  // Sink stalls on request, letting the two-entry buffer fill
  assign data_ready = ~stall;
endmodule // far_side_model

// [test/tb_fifo_status_flags_and_echo.sv]
`timescale 1ns/100ps
module tb_fifo_status_flags_and_echo;
  import fifo_flag_pkg::*;
  logic              clk, sys_rst, master_reset_n, partial_reset_n, flag_timing_select;
  logic              first_word_fall_through, input_is_byte, output_is_byte, retransmit_active;
  logic              write_clock, write_enable, read_clock, read_enable_n, read_chip_select_n;
  logic              serial_clock, serial_load_enable_n, serial_in, data_ready, stall, data_valid;
  logic              almost_full_n, almost_empty_n, half_full_n, read_clock_echo;
  logic              read_strobe_echo_n;
  logic [PTR_W-1:0]  mark_pointer, write_address, read_address, rptr;
  logic [DATA_W-1:0] read_word, data_out;
  int                num_errors, cmp_count;

  fifo_status_flags_and_echo uut (.clk, .sys_rst, .master_reset_n, .partial_reset_n,
    .flag_timing_select, .first_word_fall_through, .input_is_byte, .output_is_byte,
    .write_clock, .write_enable, .read_clock, .read_enable_n, .read_chip_select_n,
    .retransmit_active, .mark_pointer, .read_word, .serial_clock, .serial_load_enable_n,
    .serial_in, .data_ready, .write_address, .read_address, .data_out, .data_valid,
    .almost_full_n, .almost_empty_n, .half_full_n, .read_clock_echo, .read_strobe_echo_n);
  far_side_model partner (.read_address, .stall, .read_word, .data_ready);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic fl(input logic af, input logic ae, input logic hf);
    chk("almost_full_n", almost_full_n, af);
    chk("almost_empty_n", almost_empty_n, ae);
    chk("half_full_n", half_full_n, hf);
  endtask

  task automatic wr(input int k);
    repeat (k) begin
      @(posedge clk);
      write_clock <= 1'b1;
      write_enable <= 1'b1;
      @(posedge clk);
      write_clock <= 1'b0;
      write_enable <= 1'b0;
    end
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic take, input logic head);
    logic [DATA_W-1:0] e;
    e = {rptr[8:0], rptr[8:0] ^ 9'h1a5};
    if (output_is_byte) e[17:9] = 9'h000;
    @(posedge clk);
    read_clock <= 1'b1;
    read_enable_n <= 1'b0;
    read_chip_select_n <= 1'b0;
    @(posedge clk);
    read_clock <= 1'b0;
    read_enable_n <= 1'b1;
    read_chip_select_n <= 1'b1;
    #1;
    if (take) rptr = rptr + 1'b1;
    chk("read_address", read_address, rptr);
    chk("read_strobe_echo_n", read_strobe_echo_n, !take);
    chk("read_clock_echo", read_clock_echo, 1'b1);
    if (head) chk("data_out", data_out, e);
    @(posedge clk);
    #1;
  endtask

  // Full offset makes almost-full trip after four writes, five with fall-through
  task automatic mres(input logic sync, input logic ft, input logic byt);
    logic [25:0] c;
    c = {(byt ? 13'h0ffc : 13'h07fc), 13'h0002};
    @(posedge clk);
    master_reset_n <= 1'b0;
    flag_timing_select <= sync;
    first_word_fall_through <= ft;
    input_is_byte <= byt;
    output_is_byte <= byt;
    repeat (2) @(posedge clk);
    master_reset_n <= 1'b1;
    @(posedge clk);
    serial_load_enable_n <= 1'b0;
    rptr = '0;
    for (int i = 0; i < 26; i++) begin
      @(posedge clk);
      serial_in <= c[i];
      serial_clock <= 1'b1;
      @(posedge clk);
      serial_clock <= 1'b0;
    end
    // Edge with load disabled must not disturb the offsets
    serial_load_enable_n <= 1'b1;
    serial_in <= 1'b1;
    @(posedge clk);
    serial_clock <= 1'b1;
    @(posedge clk);
    serial_clock <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    {master_reset_n, partial_reset_n, read_enable_n, read_chip_select_n} = 4'hf;
    {flag_timing_select, first_word_fall_through, input_is_byte, output_is_byte} = 4'h0;
    {write_clock, write_enable, read_clock, serial_clock, serial_in, stall} = 6'h00;
    serial_load_enable_n = 1'b1;
    retransmit_active = 1'b0;
    mark_pointer = '0;
    rptr = '0;
    num_errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    fl(1'b1, 1'b0, 1'b1);
    rd(1'b0, 1'b0);
    mres(1'b0, 1'b0, 1'b0);
    wr(2);
    fl(1'b1, 1'b0, 1'b1);
    wr(1);
    fl(1'b1, 1'b1, 1'b1);
    wr(1);
    fl(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    retransmit_active <= 1'b1;
    rd(1'b1, 1'b1);
    fl(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    retransmit_active <= 1'b0;
    rd(1'b1, 1'b1);
    fl(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    stall <= 1'b1;
    wr(2);
    rd(1'b1, 1'b1);
    rd(1'b1, 1'b0);
    rd(1'b0, 1'b0);
    @(posedge clk);
    stall <= 1'b0;
    @(posedge clk);
    #1;
    chk("data_valid", data_valid, 1'b1);
    chk("data_out", data_out, {9'h003, 9'h1a6});
    repeat (2) @(posedge clk);
    #1;
    chk("data_valid", data_valid, 1'b0);
    mres(1'b1, 1'b0, 1'b0);
    wr(3);
    fl(1'b1, 1'b0, 1'b1);
    wr(1);
    fl(1'b0, 1'b0, 1'b1);
    rd(1'b1, 1'b1);
    fl(1'b0, 1'b1, 1'b1);
    mres(1'b0, 1'b0, 1'b0);
    wr(1024);
    fl(1'b0, 1'b1, 1'b1);
    wr(1);
    fl(1'b0, 1'b1, 1'b0);
    rd(1'b1, 1'b1);
    fl(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    partial_reset_n <= 1'b0;
    @(posedge clk);
    partial_reset_n <= 1'b1;
    @(posedge clk);
    #1;
    rptr = '0;
    chk("write_address", write_address, 14'h0000);
    fl(1'b1, 1'b0, 1'b1);
    wr(4);
    fl(1'b0, 1'b1, 1'b1);
    mres(1'b0, 1'b1, 1'b0);
    wr(4);
    fl(1'b1, 1'b1, 1'b1);
    wr(1);
    fl(1'b0, 1'b1, 1'b1);
    rd(1'b1, 1'b1);
    rd(1'b1, 1'b1);
    fl(1'b1, 1'b0, 1'b1);
    wr(1022);
    fl(1'b0, 1'b1, 1'b1);
    wr(1);
    fl(1'b0, 1'b1, 1'b0);
    mres(1'b0, 1'b0, 1'b1);
    wr(3);
    fl(1'b1, 1'b1, 1'b1);
    wr(1);
    fl(1'b0, 1'b1, 1'b1);
    wr(2044);
    fl(1'b0, 1'b1, 1'b1);
    wr(1);
    fl(1'b0, 1'b1, 1'b0);
    rd(1'b1, 1'b1);
    fl(1'b0, 1'b1, 1'b1);
    final_report();
  end

  // Whole run needs roughly 8600 cycles
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule // tb_fifo_status_flags_and_echo
